// *** rtl/fsr_params.svh ***
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Register offsets on the host register port
`define FSR_ADDR_PRIMARY   8'h17
`define FSR_ADDR_SECONDARY 8'h18
`define FSR_ADDR_TYPE_ID   8'h1a
`define FSR_ADDR_DASH_REV  8'h1b

// Primary status bit positions
`define FSR_B_TH_SHORT     7
`define FSR_B_GSM_BLANK    6
`define FSR_B_WINDOW       5
`define FSR_B_OVERTEMP     4
`define FSR_B_TH_TRIP      3
`define FSR_B_IND          2
`define FSR_B_FLASH_B      1
`define FSR_B_FLASH_A      0

// Secondary status bit positions
`define FSR_B_LOW_BATT     7
`define FSR_B_ILIM         6

// Flag reset value and reserved read value
`define FSR_FLAGS_RESET    8'h00
`define FSR_RSVD_LOW       6'h00
`define FSR_READ_IDLE      8'h00

// Identity nibbles, arbitrary neutral values
`define FSR_TYPE_HI        4'h0
`define FSR_TYPE_LO        4'h0
`define FSR_DASH           4'h0
`define FSR_REV            4'h0

`endif

// *** rtl/fsr_pkg.sv ***
package fsr_pkg;

	typedef struct packed {
		logic [7:0] primary;
		logic [1:0] secondary;
		logic [7:0] rdata;
		logic       rvalid;
	} fsr_state_t;

endpackage : fsr_pkg

// *** rtl/fsr_sticky_flag.sv ***
`timescale 1ns/1ns
// One latched flag with read-to-clear; a new event beats the clear.
module fsr_sticky_flag (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Event and clear
	input  wire logic event_in,
	input  wire logic clear,
	// Flag
	output logic      flag
);
	logic flag_q;
	logic flag_d;

	always_comb begin
		flag_d = flag_q;
		if (clear)
			flag_d = 1'b0;
		// R17 set beats clear
		if (event_in)
			flag_d = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;

	a_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
		event_in |=> flag_q) // R17
		else $error("flag lost an event");

	a_clear_works: assert property (@(posedge clock) disable iff (!rst_n)
		clear && !event_in |=> !flag_q) // R2
		else $error("flag not cleared by read");

	a_hold_flag: assert property (@(posedge clock) disable iff (!rst_n)
		flag_q && !clear |=> flag_q) // R1
		else $error("flag dropped without read");

endmodule : fsr_sticky_flag

// *** rtl/fsr_status_regs.sv ***
`timescale 1ns/1ns
`include "fsr_params.svh"
// Functional notes
// R1 - Each fault or event flag latches on its condition and holds until its register is read.
// R2 - Reading a status register returns the latched flags and then clears them.
// R3 - A condition still present after the clearing read sets its flag again.
// R4 - Primary bit 7 reports a thermistor input short.
// R5 - Primary bit 6 reports that a GSM blanking event has occurred.
// R6 - Primary bit 5 reports the output leaving its power-good window.
// R7 - Primary bit 4 reports a die overtemperature event.
// R8 - Primary bit 3 reports the thermistor threshold having tripped.
// R9 - Primary bits 2, 1, 0 report indicator, flash B and flash A channel faults.
// R10 - Secondary bit 7 reports a low-battery flash reduction since last read.
// R11 - Secondary bit 6 reports the input current limit hit during blanking.
// R12 - Secondary bits 5 to 0 are reserved and read zero.
// R13 - The type id register returns two BCD characters of die type.
// R14 - The dash/revision register upper nibble holds the dash number, 0 for plain.
// R15 - The dash/revision register lower nibble holds the mask revision.
// R16 - Both id registers are fixed values that no write or reset changes.
// R17 - An event in the same cycle as the clearing read keeps its flag set.
module fsr_status_regs #(
	parameter logic [3:0] TYPE_HI = `FSR_TYPE_HI,
	parameter logic [3:0] TYPE_LO = `FSR_TYPE_LO,
	parameter logic [3:0] DASH    = `FSR_DASH,
	parameter logic [3:0] REV     = `FSR_REV
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// Detector levels from analog, asynchronous
	input  wire logic       thermistor_short_fault,
	input  wire logic       gsm_blank_event,
	input  wire logic       output_window_fault,
	input  wire logic       die_overtemp,
	input  wire logic       thermistor_threshold_trip,
	input  wire logic       indicator_channel_fault,
	input  wire logic       flash_channel_b_fault,
	input  wire logic       flash_channel_a_fault,
	input  wire logic       low_battery_reduction_event,
	input  wire logic       blank_input_current_limit_hit,
	// Register read port from the serial host interface
	input  wire logic       rd_strobe,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	output logic            rd_valid
);

	// BCD digits only
	initial begin
		if (TYPE_HI > 4'h9 || TYPE_LO > 4'h9 || DASH > 4'h9 || REV > 4'h9)
			$error("identity nibbles must be BCD");
	end

	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// Detectors are analog levels; two stages before any use
	localparam int NDET = 10;
	logic [NDET-1:0] det_raw;
	logic [NDET-1:0] det_s1_q;
	logic [NDET-1:0] det_s2_q;

	assign det_raw = {thermistor_short_fault, gsm_blank_event,
		output_window_fault, die_overtemp, thermistor_threshold_trip,
		indicator_channel_fault, flash_channel_b_fault,
		flash_channel_a_fault, low_battery_reduction_event,
		blank_input_current_limit_hit};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			det_s1_q <= 10'h000;
			det_s2_q <= 10'h000;
		end else begin
			det_s1_q <= det_raw;
			det_s2_q <= det_s1_q;
		end
	end

	logic rd_primary;
	logic rd_secondary;
	assign rd_primary   = rd_strobe && rd_addr == `FSR_ADDR_PRIMARY;
	assign rd_secondary = rd_strobe && rd_addr == `FSR_ADDR_SECONDARY;

	logic [7:0] prim_flags;
	logic [1:0] sec_flags;

	// R1 latch each flag
	// R3 live condition re-sets
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_prim
			fsr_sticky_flag u_flag (
				.clock    (clock),
				.rst_n    (rst_n),
				.event_in (det_s2_q[gi+2]),
				.clear    (rd_primary),
				.flag     (prim_flags[gi])
			);
		end
		for (gi = 0; gi < 2; gi++) begin : g_sec
			fsr_sticky_flag u_flag (
				.clock    (clock),
				.rst_n    (rst_n),
				.event_in (det_s2_q[gi]),
				.clear    (rd_secondary),
				.flag     (sec_flags[gi])
			);
		end
	endgenerate

	fsr_pkg::fsr_state_t s_q;
	fsr_pkg::fsr_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.primary   = prim_flags;
		s_d.secondary = sec_flags;
		s_d.rvalid    = rd_strobe;
		s_d.rdata     = `FSR_READ_IDLE;
		if (rd_strobe) begin
			unique case (rd_addr)
				// R2 return latched flags
				// R4 thermistor short at top bit
				// R9 channel faults in low bits
				// R5 R6 R7 R8 middle bits
				`FSR_ADDR_PRIMARY:   s_d.rdata = prim_flags;
				// R10 low battery bit 7
				// R11 current limit bit 6
				// R12 reserved low bits zero
				`FSR_ADDR_SECONDARY: s_d.rdata = {sec_flags, `FSR_RSVD_LOW};
				// R13 die type BCD pair
				`FSR_ADDR_TYPE_ID:   s_d.rdata = {TYPE_HI, TYPE_LO};
				// R14 dash upper nibble
				// R15 revision lower nibble
				`FSR_ADDR_DASH_REV:  s_d.rdata = {DASH, REV};
				default:             s_d.rdata = `FSR_READ_IDLE;
			endcase
		end
	end

	// R16 ids are constants, not state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rd_data  = s_q.rdata;
	assign rd_valid = s_q.rvalid;

	// Bit positions: R5 gsm, R6 window, R8 trip, R11 ilim
	a_gsm_bit: assert property (@(posedge clock) disable iff (!rst_n)
		rd_primary && prim_flags[`FSR_B_GSM_BLANK]
		|=> rd_data[`FSR_B_GSM_BLANK]) // R5
		else $error("blank flag missing");

	a_window_bit: assert property (@(posedge clock) disable iff (!rst_n)
		rd_primary |=> rd_data[`FSR_B_WINDOW]
		== $past(prim_flags[`FSR_B_WINDOW])) // R6
		else $error("window flag wrong");

	a_ilim_bit: assert property (@(posedge clock) disable iff (!rst_n)
		rd_secondary |=> rd_data[`FSR_B_ILIM] == $past(sec_flags[0])) // R11
		else $error("current limit flag wrong");

	a_rsvd_zero: assert property (@(posedge clock) disable iff (!rst_n)
		rd_valid && $past(rd_secondary) |-> rd_data[5:0] == 6'h00) // R12
		else $error("reserved bits not zero");

	a_id_fixed: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rd_strobe && rd_addr == `FSR_ADDR_DASH_REV)
		|-> rd_data == {DASH, REV}) // R16
		else $error("id register changed");

	a_rearm_cond: assert property (@(posedge clock) disable iff (!rst_n)
		rd_primary && det_s2_q[`FSR_B_OVERTEMP+2]
		|=> prim_flags[`FSR_B_OVERTEMP]) // R3
		else $error("persisting fault not re-set");

	a_trip_latch: assert property (@(posedge clock) disable iff (!rst_n)
		det_s2_q[`FSR_B_TH_TRIP+2] |=> prim_flags[`FSR_B_TH_TRIP]
		[*1] ##0 prim_flags[`FSR_B_TH_TRIP]) // R8
		else $error("trip not latched");

	a_clear_after: assert property (@(posedge clock) disable iff (!rst_n)
		rd_secondary && !det_s2_q[1] |=> !sec_flags[1]) // R2
		else $error("secondary not cleared");

endmodule : fsr_status_regs

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
	logic       clock;
	logic       rstn;
	logic [9:0] det;
	logic       rd_strobe;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       rd_valid;
	logic [7:0] exp_q[$];
	int         miscompares = 0;
	int         checks_done = 0;
	int         cycles      = 0;

	// Arbitrary identity nibbles, distinct so a swapped field shows up
	fsr_status_regs #(
		.TYPE_HI(4'h2),
		.TYPE_LO(4'h5),
		.DASH   (4'h0),
		.REV    (4'h3)
	) DUT (
		.clock                        (clock),
		.rstn                         (rstn),
		.thermistor_short_fault       (det[7]),
		.gsm_blank_event              (det[6]),
		.output_window_fault          (det[5]),
		.die_overtemp                 (det[4]),
		.thermistor_threshold_trip    (det[3]),
		.indicator_channel_fault      (det[2]),
		.flash_channel_b_fault        (det[1]),
		.flash_channel_a_fault        (det[0]),
		.low_battery_reduction_event  (det[9]),
		.blank_input_current_limit_hit(det[8]),
		.rd_strobe                    (rd_strobe),
		.rd_addr                      (rd_addr),
		.rd_data                      (rd_data),
		.rd_valid                     (rd_valid)
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		checks_done++;
		if (seen !== expd) begin
			miscompares++;
			$display("unexpected rd_data: expected %h, seen %h", expd, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		rd_strobe <= 1'b1;
		rd_addr   <= a;
		exp_q.push_back(e);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clock);
			rd_strobe <= 1'b0;
		end
	endtask : idle

	// Pulse of 3 cycles covers the two-flop synchroniser
	task automatic pulse_check(input logic [9:0] p);
		idle(1);
		det <= p;
		idle(3);
		det <= 10'h000;
		idle(4);
		rd(8'h17, p[7:0]);
		rd(8'h18, {p[9:8], 6'h00});
		rd(8'h17, 8'h00);
		rd(8'h18, 8'h00);
	endtask : pulse_check

	// Oldest note is matched against each answer, mid-cycle so the
	// registered answer has settled and no edge race can hide it
	always @(negedge clock) begin
		cycles++;
		if (cycles > 2000) begin
			miscompares++;
			test_done();
		end
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("unexpected rd_valid: expected 0, seen 1");
			end else
				check(rd_data, exp_q.pop_front());
		end
	end

	initial begin
		rstn      = 1'b0;
		rd_strobe = 1'b0;
		rd_addr   = 8'h00;
		det       = 10'h000;
		void'($urandom(14698));
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		idle(3);
		rd(8'h1a, 8'h25);
		rd(8'h1b, 8'h03);
		rd(8'h17, 8'h00);
		rd(8'h18, 8'h00);
		rd(8'h19, 8'h00);
		for (int i = 0; i < 10; i++) begin
			pulse_check(10'h001 << i);
		end
		repeat (8) pulse_check(10'($urandom));
		idle(1);
		det <= 10'h3ff;
		idle(6);
		rd(8'h17, 8'hff);
		rd(8'h17, 8'hff);
		rd(8'h18, 8'hc0);
		idle(1);
		det <= 10'h000;
		idle(6);
		rd(8'h17, 8'hff);
		rd(8'h17, 8'h00);
		rd(8'h18, 8'hc0);
		rd(8'h18, 8'h00);
		// reset in mid-run leaves ids alone
		idle(1);
		det <= 10'h3ff;
		idle(6);
		rstn <= 1'b0;
		det  <= 10'h000;
		idle(6);
		rstn <= 1'b1;
		idle(3);
		rd(8'h17, 8'h00);
		rd(8'h1a, 8'h25);
		rd(8'h1b, 8'h03);
		idle(4);
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("unexpected answers: expected %0d more, seen 0",
				exp_q.size());
		end
		test_done();
	end
endmodule : tb
